// ### swd_pkg.sv
// Package with constants and types for the system watchdog
//
// Functional notes
// [RL1] On countdown expiry, assert the system reset output.
// [RL2] Software initializes the watchdog before any other operation.
// [RL3] Accept a timeout in seconds, loaded before start.
// [RL4] Timeouts 0 to 255 count in one-second steps.
// [RL5] Above 255, count minutes equal to seconds divided by 60 plus one.
// [RL6] Start begins counting down from the loaded timeout.
// [RL7] Software reloads or stops the watchdog before each expiry.
// [RL8] Reload restores the countdown to the last loaded timeout.
// [RL9] Stop halts counting; no expiry until started again.
// [RL10] Each operation reports success or failure to software.
`default_nettype none
package swd_pkg;
	// Clock rate and base tick
	localparam int unsigned CLK_HZ           = 200_000_000;
	localparam int unsigned TICK_SEC_NS      = 1_000_000_000;
	localparam int unsigned CLK_PERIOD_NS    = 1_000_000_000 / CLK_HZ;
	localparam int unsigned SEC_CYCLES       = TICK_SEC_NS / CLK_PERIOD_NS;
	localparam int unsigned SECS_PER_MIN     = 60;
	// Timeout encoding
	localparam int unsigned TIMEOUT_W        = 32;
	localparam int unsigned COUNT_W          = 32;
	localparam logic [TIMEOUT_W-1:0] SEC_RES_MAX = 32'h0000_00ff;
	// Operation codes
	typedef enum logic [2:0] {
		SWD_OP_INIT   = 3'h0,
		SWD_OP_LOAD   = 3'h1,
		SWD_OP_START  = 3'h2,
		SWD_OP_RELOAD = 3'h3,
		SWD_OP_STOP   = 3'h4
	} swd_op_e;
	// Controller states
	typedef enum logic [1:0] {
		SWD_ST_UNINIT,
		SWD_ST_IDLE,
		SWD_ST_RUN,
		SWD_ST_EXPIRED
	} swd_state_e;
endpackage
`default_nettype wire

// ### swd_tick_if.sv
// Interface between controller and tick prescaler
`default_nettype none
interface swd_tick_if;
	logic run;
	logic restart;
	logic minute_res;
	logic tick;
	modport ctrl (output run, output restart, output minute_res, input tick);
	modport gen  (input run, input restart, input minute_res, output tick);
endinterface
`default_nettype wire

// ### swd_prescaler.sv
// Prescaler making one-second or one-minute ticks
`default_nettype none
module swd_prescaler (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic sys_rst_i,
	// Controller link
	swd_tick_if.gen   tk
);
	logic [31:0] cyc_q, cyc_d;
	logic [5:0]  sec_q, sec_d;
	logic        tick_q, tick_d;

	assign tk.tick = tick_q;

	// Next prescaler values
	always_comb begin
		cyc_d  = cyc_q;
		sec_d  = sec_q;
		tick_d = 1'b0;
		if (!tk.run || tk.restart) begin
			cyc_d = '0;
			sec_d = '0;
		end else if (cyc_q == 32'(swd_pkg::SEC_CYCLES - 1)) begin
			cyc_d = '0;
			if (!tk.minute_res) begin
				tick_d = 1'b1; // [RL4]
			end else if (sec_q == 6'(swd_pkg::SECS_PER_MIN - 1)) begin
				sec_d  = '0;
				tick_d = 1'b1; // [RL5]
			end else begin
				sec_d = sec_q + 6'h01;
			end
		end else begin
			cyc_d = cyc_q + 32'h1;
		end
	end

	// Prescaler registers
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cyc_q  <= '0;
			sec_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cyc_q  <= cyc_d;
			sec_q  <= sec_d;
			tick_q <= tick_d;
		end
	end
endmodule
`default_nettype wire

// ### swd_watchdog.sv
// System watchdog top: operation port, countdown and reset output
`default_nettype none
module swd_watchdog (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        sys_rst_i,
	// Operation request
	input  wire logic        op_valid_i,
	input  wire logic [2:0]  op_code_i,
	input  wire logic [31:0] op_timeout_i,
	// Operation answer
	output logic             op_done_o,
	output logic             op_ok_o,
	// Status and system reset
	output logic             running_o,
	output logic             sys_reset_req_o
);
	// Link to the tick prescaler
	swd_tick_if tk ();

	// Controller state and running countdown
	swd_pkg::swd_state_e st_q, st_d;
	logic [31:0]         cnt_q, cnt_d;
	logic                actres_q, actres_d;

	// Last loaded timeout and its resolution
	logic [31:0]         init_q, init_d;
	logic                minres_q, minres_d;
	logic                loaded_q, loaded_d;

	// Answer and system reset request
	logic                done_q, done_d;
	logic                ok_q, ok_d;
	logic                rst_q, rst_d;

	// Decoded request of this cycle
	logic                accept;
	logic                do_init;
	logic                do_load;
	logic                do_start;
	logic                do_reload;
	logic                do_stop;
	logic                restart;
	logic                expire;

	// Initialised and not expired
	function automatic logic swd_armed(input swd_pkg::swd_state_e st);
		return (st == swd_pkg::SWD_ST_IDLE) || (st == swd_pkg::SWD_ST_RUN);
	endfunction

	// Success of a request in a given state
	// Only init is taken before init or after expiry
	// Unknown codes always fail and change nothing
	function automatic logic swd_accept(
		input swd_pkg::swd_state_e st,
		input logic [2:0]          code,
		input logic                loaded
	);
		logic ok;
		ok = 1'b0;
		case (code)
			swd_pkg::SWD_OP_INIT:   ok = (st != swd_pkg::SWD_ST_RUN);
			swd_pkg::SWD_OP_LOAD:   ok = swd_armed(st); // [RL2]
			swd_pkg::SWD_OP_START:  ok = (st == swd_pkg::SWD_ST_IDLE) && loaded;
			swd_pkg::SWD_OP_RELOAD: ok = (st == swd_pkg::SWD_ST_RUN);
			swd_pkg::SWD_OP_STOP:   ok = swd_armed(st);
			default:                ok = 1'b0; // [RL10]
		endcase
		return ok;
	endfunction

	// Coarse range: whole minutes, truncated, plus one
	function automatic logic [31:0] swd_minutes(input logic [31:0] secs);
		return secs / 32'(swd_pkg::SECS_PER_MIN) + 32'h1;
	endfunction

	// Second and minute tick source
	// Restarted on start and reload so a count never starts mid-second
	swd_prescaler swd_prescaler_inst (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.tk        (tk)
	);

	// Request decode; one request per cycle
	// Refused requests decode to nothing
	assign accept    = op_valid_i && swd_accept(st_q, op_code_i, loaded_q);
	assign do_init   = accept && (op_code_i == swd_pkg::SWD_OP_INIT);
	assign do_load   = accept && (op_code_i == swd_pkg::SWD_OP_LOAD);
	assign do_start  = accept && (op_code_i == swd_pkg::SWD_OP_START);
	assign do_reload = accept && (op_code_i == swd_pkg::SWD_OP_RELOAD);
	assign do_stop   = accept && (op_code_i == swd_pkg::SWD_OP_STOP);
	assign restart   = do_start || do_reload;

	// Prescaler control
	assign tk.run        = (st_q == swd_pkg::SWD_ST_RUN);
	assign tk.restart    = restart;
	assign tk.minute_res = actres_q;

	// Outputs straight from registers, except running_o decoded from st_q
	assign op_done_o       = done_q;
	assign op_ok_o         = ok_q;
	assign running_o       = tk.run;
	assign sys_reset_req_o = rst_q;

	// Next loaded timeout
	// Init forgets the load; a load while running only
	// takes effect at the next start or reload
	always_comb begin
		init_d   = init_q;
		minres_d = minres_q;
		loaded_d = loaded_q;
		if (do_init) begin
			loaded_d = 1'b0;
		end else if (do_load) begin
			loaded_d = 1'b1;
			if (op_timeout_i <= swd_pkg::SEC_RES_MAX) begin
				minres_d = 1'b0;
				init_d   = op_timeout_i; // [RL3] [RL4]
			end else begin
				minres_d = 1'b1;
				init_d   = swd_minutes(op_timeout_i); // [RL5]
			end
		end
	end

	// Loaded timeout registers
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			init_q   <= '0;
			minres_q <= 1'b0;
			loaded_q <= 1'b0;
		end else begin
			init_q   <= init_d;
			minres_q <= minres_d;
			loaded_q <= loaded_d;
		end
	end

	// Next state, countdown and active resolution
	// Resolution is latched with the count, so a load in flight
	// cannot stretch or shrink the running countdown
	// Reload or stop in the expiry cycle wins over expiry
	always_comb begin
		st_d     = st_q;
		cnt_d    = cnt_q;
		actres_d = actres_q;
		expire   = 1'b0;
		if (do_init) begin
			st_d = swd_pkg::SWD_ST_IDLE;
		end else if (do_start) begin
			st_d     = swd_pkg::SWD_ST_RUN;
			cnt_d    = init_q; // [RL6]
			actres_d = minres_q;
		end else if (do_reload) begin
			cnt_d    = init_q; // [RL8]
			actres_d = minres_q;
		end else if (do_stop) begin
			st_d = swd_pkg::SWD_ST_IDLE; // [RL9]
		end else if (st_q == swd_pkg::SWD_ST_RUN) begin
			if (cnt_q == '0) begin
				st_d   = swd_pkg::SWD_ST_EXPIRED;
				expire = 1'b1; // [RL1]
			end else if (tk.tick) begin
				cnt_d = cnt_q - 32'h1;
			end
		end
	end

	// State and countdown registers
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_q     <= swd_pkg::SWD_ST_UNINIT;
			cnt_q    <= '0;
			actres_q <= 1'b0;
		end else begin
			st_q     <= st_d;
			cnt_q    <= cnt_d;
			actres_q <= actres_d;
		end
	end

	// Next answer: every request answered once, next cycle
	always_comb begin
		done_d = op_valid_i; // [RL10]
		ok_d   = accept; // [RL10]
	end

	// Answer registers
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			done_q <= 1'b0;
			ok_q   <= 1'b0;
		end else begin
			done_q <= done_d;
			ok_q   <= ok_d;
		end
	end

	// Next system reset request
	// Held until init or reset; expiry wins if both fall together
	always_comb begin
		rst_d = rst_q;
		if (expire) begin
			rst_d = 1'b1; // [RL1]
		end else if (do_init) begin
			rst_d = 1'b0;
		end
	end

	// System reset request register
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rst_q <= 1'b0;
		end else begin
			rst_q <= rst_d;
		end
	end
endmodule
`default_nettype wire

// ### swd_checker.sv
// Assertions on the watchdog ports
`default_nettype none
module swd_chk (
	// Watched ports
	input wire logic       ref_clk_i,
	input wire logic       sys_rst_i,
	input wire logic       op_valid_i,
	input wire logic [2:0] op_code_i,
	input wire logic       op_done_o,
	input wire logic       op_ok_o,
	input wire logic       running_o,
	input wire logic       sys_reset_req_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	// Answers and countdown control
	property p_ans; op_valid_i |=> op_done_o; endproperty
	property p_quiet; !op_valid_i |=> !op_done_o; endproperty
	property p_unk; op_valid_i && op_code_i > 3'h4 |=> !op_ok_o; endproperty
	property p_go; op_valid_i && op_code_i == 3'h2 |=> op_ok_o |-> running_o; endproperty
	property p_halt; op_valid_i && op_code_i == 3'h4 |=> op_ok_o |-> !running_o; endproperty
	property p_exp; $rose(sys_reset_req_o) |-> $past(running_o); endproperty
	property p_excl; sys_reset_req_o |-> !running_o; endproperty
	property p_hold; sys_reset_req_o && !(op_valid_i && op_code_i == 3'h0) |=> sys_reset_req_o;
	endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	a_quiet: assert property (p_quiet) else $error("stray answer");
	a_unk: assert property (p_unk) else $error("bad code accepted");
	a_go: assert property (p_go) else $error("start not running");
	a_halt: assert property (p_halt) else $error("stop still running");
	a_exp: assert property (p_exp) else $error("reset while idle");
	a_excl: assert property (p_excl) else $error("running in reset");
	a_hold: assert property (p_hold) else $error("reset dropped");
	// Main scenarios
	c_go: cover property (op_valid_i && op_code_i == 3'h2 ##1 op_ok_o);
	c_exp: cover property ($rose(sys_reset_req_o));
	c_fail: cover property (op_done_o && !op_ok_o);
endmodule
bind swd_watchdog swd_chk swd_chk_inst (.ref_clk_i, .sys_rst_i, .op_valid_i, .op_code_i,
	.op_done_o, .op_ok_o, .running_o, .sys_reset_req_o);
`default_nettype wire

// ### test_system_watchdog_timer.sv
// Self-checking bench for the watchdog
`default_nettype none
module test_system_watchdog_timer;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        vld = 1'b0;
	logic [2:0]  cod = 3'h0;
	logic [31:0] tmo = 32'h0;
	logic        done, ok, run, srst;
	logic        exp_q[$];
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cyc = 0;
	always #2.5 clk = ~clk;
	swd_watchdog swd_watchdog_inst (.ref_clk_i(clk), .sys_rst_i(rst), .op_valid_i(vld),
		.op_code_i(cod), .op_timeout_i(tmo), .op_done_o(done), .op_ok_o(ok),
		.running_o(run), .sys_reset_req_o(srst));
	// Compare one bit
	task automatic chk(input string n, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %b got %b", n, e, g);
		end
	endtask
	// One operation, answer noted
	task automatic op(input logic [2:0] c, input logic [31:0] t, input logic e);
		@(posedge clk);
		vld <= 1'b1;
		cod <= c;
		tmo <= t;
		exp_q.push_back(e);
		@(posedge clk);
		vld <= 1'b0;
		#1;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Answer against oldest note
	always @(posedge clk) begin
		if (done === 1'b1)
			chk("op_ok_o", exp_q.size() > 0 ? exp_q.pop_front() : 1'bx, ok);
	end
	// Hang limit
	always @(posedge clk) begin
		cyc++;
		if (cyc == 500) begin
			error_cnt++;
			give_verdict();
		end
	end
	initial begin
		logic [31:0] t;
		void'($urandom(32'h841c22ec));
		t = 32'h1 + ($urandom % 255);
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		op(3'h1, t, 1'b0);
		for (int c = 5; c < 8; c++) op(c[2:0], t, 1'b0);
		op(3'h0, t, 1'b1);
		op(3'h2, t, 1'b0);
		op(3'h3, t, 1'b0);
		op(3'h1, 32'd300, 1'b1);
		op(3'h1, t, 1'b1);
		for (int k = 5; k < 8; k++) op(k[2:0], t, 1'b0);
		op(3'h2, t, 1'b1);
		chk("running_o", 1'b1, run);
		op(3'h3, t, 1'b1);
		op(3'h0, t, 1'b0);
		op(3'h4, t, 1'b1);
		chk("running_o", 1'b0, run);
		op(3'h3, t, 1'b0);
		$display("control test done");
		op(3'h1, 32'h100, 1'b1);
		op(3'h2, t, 1'b1);
		op(3'h1, 32'h0, 1'b1);
		chk("sys_reset_req_o", 1'b0, srst);
		chk("running_o", 1'b1, run);
		op(3'h3, 32'h0, 1'b1);
		@(posedge clk);
		#1;
		chk("sys_reset_req_o", 1'b1, srst);
		op(3'h0, 32'h0, 1'b1);
		chk("sys_reset_req_o", 1'b0, srst);
		$display("reload test done");
		op(3'h1, 32'h0, 1'b1);
		op(3'h2, 32'h0, 1'b1);
		repeat (3) @(posedge clk);
		#1;
		chk("sys_reset_req_o", 1'b1, srst);
		op(3'h1, t, 1'b0);
		op(3'h0, t, 1'b1);
		chk("sys_reset_req_o", 1'b0, srst);
		@(posedge clk);
		#1;
		chk("pending", 1'b1, exp_q.size() == 0);
		$display("expiry test done");
		give_verdict();
	end
endmodule
`default_nettype wire
